// File: design/mqf_top.sv
// Multi-queue flow FIFO: up to four queues behind shared write and read ports
// Behaviour
// R1 - One to four queues share both data ports
// R2 - Write and read selects pick independent queues
// R3 - Full for write queue, valid for read queue
// R4 - Almost-full and almost-empty buses, one bit per queue
// R5 - Port widths 9, 18 or 36, one wide
// R6 - Narrow words packed little-endian into 36 bits
// R7 - Packet mode only at 36/36, per-queue packet ready
// R8 - Counts, depths, thresholds programmed, else default setup
// R9 - Default is four equal 36-bit queues
// R10 - Master reset captures setup; precedes programming
// R11 - Storage allocated in 256-word blocks at master reset
// R12 - Partial reset clears one queue selected on both
// R13 - Read port falls through without read request
// R14 - One write and one read every cycle
// R15 - Up to eight devices share the flag buses
// R16 - Writes take effect only while queue not full
// R17 - Switching to empty queue keeps last word
// R18 - First word bit 34, last word bit 35
// R19 - Valid drops when nothing new, rises on load
//
// Implementation choices: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module mqf_top #(
  parameter int TOTAL_BLOCKS = mqf_pkg::TOTAL_BLOCKS_DEF,
  parameter logic [mqf_pkg::EXP_W-1:0] DEVICE_INDEX = 3'h0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [mqf_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [mqf_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire mqf_pkg::mqf_wr_port_t write_port,
  input wire mqf_pkg::mqf_rd_port_t read_port,
  input wire logic partial_reset_n,
  input wire logic [mqf_pkg::EXP_W-1:0] af_bus_select,
  input wire logic [mqf_pkg::EXP_W-1:0] ae_bus_select,
  output logic [mqf_pkg::DW-1:0] read_data,
  output logic read_word_valid,
  output logic write_queue_full,
  output logic packet_available_flag,
  output logic [mqf_pkg::NQ-1:0] almost_full_flag,
  output logic almost_full_flag_oe,
  output logic [mqf_pkg::NQ-1:0] almost_empty_flag,
  output logic almost_empty_flag_oe,
  output logic irq
);
  import mqf_pkg::*;

  localparam int TOTAL_WORDS = TOTAL_BLOCKS * BLOCK_WORDS;
  localparam int AW = $clog2(TOTAL_WORDS);
  localparam int CW = AW + 1;
  localparam int DEF_BLOCKS = TOTAL_BLOCKS / NQ;

  // Register bus state
  logic aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg;
  logic [AXI_AW-1:0] awaddr_reg;
  logic [31:0] wdata_reg, rdata_reg;
  logic [3:0] wstrb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  // Configuration and interrupt state
  mqf_cfg_t cfg_reg, cfg_pend_reg;
  logic [QBLK_W-1:0] qblk_pend_reg [NQ];
  logic [THR_W-1:0] af_off_reg [NQ];
  logic [THR_W-1:0] ae_off_reg [NQ];
  logic [IRQ_W-1:0] irq_stat_reg, irq_mask_reg, irq_event;
  // Queue state
  logic [DW-1:0] mem [TOTAL_WORDS];
  logic [AW-1:0] base_reg [NQ];
  logic [AW-1:0] base_next [NQ];
  logic [CW-1:0] depth_reg [NQ];
  logic [CW-1:0] depth_next [NQ];
  logic [CW-1:0] wptr_reg [NQ];
  logic [CW-1:0] rptr_reg [NQ];
  logic [CW-1:0] rptr_next [NQ];
  logic [CW-1:0] cnt_reg [NQ];
  logic [CW-1:0] cnt_next [NQ];
  logic [CW-1:0] eop_cnt_reg [NQ];
  logic [NQ-1:0] full_vec, empty_vec, af_vec, ae_vec, pkt_rdy_vec, active_vec;
  // Port state
  logic [1:0] wr_piece_reg, rd_piece_reg;
  logic [DW-1:0] wr_acc_reg, out_reg, commit_word, head_word;
  logic out_valid_reg;
  logic [QSEL_W-1:0] shown_q_reg, wsel, rsel;
  logic [NQ-1:0] af_bus_reg, ae_bus_reg;
  logic wr_take, wr_commit, rd_last, pop, prst, need_load, cfg_apply, cfg_ok;
  logic do_write, wr_known, rd_known;
  int blk_sum;

  // Registers sit on aligned words up to 0x14 and from 0x20 below 0x50; anything else is refused
  function automatic logic mqf_reg_known(logic [AXI_AW-1:0] a);
    mqf_reg_known = (a[1:0] == 2'b00) && ((a <= REG_IRQ_MASK) ||
                    (a >= REG_AF_BASE && a < 8'h50));
  endfunction : mqf_reg_known

  function automatic logic [31:0] mqf_merge(logic [31:0] old, logic [31:0] nw, logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        old[8*b +: 8] = nw[8*b +: 8];
      end
    end
    mqf_merge = old;
  endfunction : mqf_merge

  assign wsel = write_port.write_queue_select;
  assign rsel = read_port.read_queue_select;

  // AXI4-Lite handshakes; address and data may arrive in either order
  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready = !w_held_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_known = mqf_reg_known(awaddr_reg);
  assign rd_known = mqf_reg_known(s_axi_araddr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      bresp_reg <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held_reg) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_reg) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Read answers one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= rd_known ? RESP_OKAY : RESP_SLVERR;
      rdata_reg <= '0;
      if (s_axi_araddr == REG_CFG) begin
        rdata_reg <= {25'h0, cfg_pend_reg};
      end else if (s_axi_araddr == REG_QBLK) begin
        rdata_reg <= {qblk_pend_reg[3], qblk_pend_reg[2], qblk_pend_reg[1], qblk_pend_reg[0]};
      end else if (s_axi_araddr == REG_STATUS) begin
        rdata_reg <= {13'h0, cfg_reg, pkt_rdy_vec, full_vec, empty_vec};
      end else if (s_axi_araddr == REG_IRQ_STAT) begin
        rdata_reg <= {29'h0, irq_stat_reg};
      end else if (s_axi_araddr == REG_IRQ_MASK) begin
        rdata_reg <= {29'h0, irq_mask_reg};
      end else if (s_axi_araddr[7:4] == REG_AF_BASE[7:4]) begin
        rdata_reg <= {16'h0, af_off_reg[s_axi_araddr[3:2]]};
      end else if (s_axi_araddr[7:4] == REG_AE_BASE[7:4]) begin
        rdata_reg <= {16'h0, ae_off_reg[s_axi_araddr[3:2]]};
      end else if (s_axi_araddr[7:4] == REG_QCNT_BASE[7:4]) begin
        rdata_reg <= 32'(cnt_reg[s_axi_araddr[3:2]]);
      end
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Setup held in software registers; all but the thresholds and interrupt mask waits for a master reset to capture it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_pend_reg <= CFG_RESET; // see R9
      irq_mask_reg <= IRQ_MASK_RESET;
      for (int q = 0; q < NQ; q++) begin
        qblk_pend_reg[q] <= QBLK_W'(DEF_BLOCKS);
        af_off_reg[q] <= AF_OFF_RESET;
        ae_off_reg[q] <= AE_OFF_RESET;
      end
    end else if (do_write && wr_known) begin // see R8
      if (awaddr_reg == REG_CFG) begin
        cfg_pend_reg <= mqf_cfg_t'(7'(mqf_merge(32'(cfg_pend_reg), wdata_reg, wstrb_reg)));
      end else if (awaddr_reg == REG_QBLK) begin
        for (int q = 0; q < NQ; q++) begin
          if (wstrb_reg[q]) begin
            qblk_pend_reg[q] <= wdata_reg[8*q +: 8];
          end
        end
      end else if (awaddr_reg == REG_IRQ_MASK && wstrb_reg[0]) begin
        irq_mask_reg <= wdata_reg[IRQ_W-1:0];
      end else if (awaddr_reg[7:4] == REG_AF_BASE[7:4]) begin
        af_off_reg[awaddr_reg[3:2]] <= 16'(mqf_merge(32'(af_off_reg[awaddr_reg[3:2]]),
                                                     wdata_reg, wstrb_reg));
      end else if (awaddr_reg[7:4] == REG_AE_BASE[7:4]) begin
        ae_off_reg[awaddr_reg[3:2]] <= 16'(mqf_merge(32'(ae_off_reg[awaddr_reg[3:2]]),
                                                     wdata_reg, wstrb_reg));
      end
    end
  end

  // Block allocation: queues laid end to end in 256-word blocks
  always_comb begin
    blk_sum = 0;
    for (int q = 0; q < NQ; q++) begin
      if (q <= int'(cfg_pend_reg.qnum_m1)) begin // see R1
        base_next[q] = AW'(blk_sum * BLOCK_WORDS); // see R11
        depth_next[q] = CW'(int'(qblk_pend_reg[q]) * BLOCK_WORDS);
        blk_sum = blk_sum + int'(qblk_pend_reg[q]);
      end else begin
        base_next[q] = '0;
        depth_next[q] = '0;
      end
    end
  end

  // At least one wide port, and the blocks must fit the pool
  assign cfg_ok = (cfg_pend_reg.in_w == MQF_W36 || cfg_pend_reg.out_w == MQF_W36) && // see R5
                  cfg_pend_reg.in_w != 2'd3 && cfg_pend_reg.out_w != 2'd3 &&
                  blk_sum <= TOTAL_BLOCKS;
  assign cfg_apply = do_write && awaddr_reg == REG_CTRL && wstrb_reg[0] && wdata_reg[0];

  // Master reset: a refused setup leaves the old one running
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_reg <= CFG_RESET;
      for (int q = 0; q < NQ; q++) begin
        base_reg[q] <= AW'(q * DEF_BLOCKS * BLOCK_WORDS); // see R9
        depth_reg[q] <= CW'(DEF_BLOCKS * BLOCK_WORDS);
      end
    end else if (cfg_apply && cfg_ok) begin // see R10
      cfg_reg <= cfg_pend_reg;
      // Packet marks are only meaningful when whole words cross both ports
      cfg_reg.pkt_mode <= cfg_pend_reg.pkt_mode && cfg_pend_reg.in_w == MQF_W36 &&
                          cfg_pend_reg.out_w == MQF_W36; // see R7
      base_reg <= base_next;
      depth_reg <= depth_next;
    end
  end

  // Write side: collect narrow pieces, lowest piece first
  assign wr_take = write_port.wr_en && !full_vec[wsel]; // see R16
  assign wr_commit = wr_take && wr_piece_reg == mqf_last_piece(cfg_reg.in_w);
  always_comb begin
    unique case (cfg_reg.in_w)
      MQF_W18: commit_word = {write_port.data[17:0], wr_acc_reg[17:0]}; // see R6
      MQF_W9: commit_word = {write_port.data[8:0], wr_acc_reg[26:0]};
      default: commit_word = write_port.data;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || cfg_apply) begin
      wr_piece_reg <= '0;
      wr_acc_reg <= '0;
    end else if (wr_take && !wr_commit) begin
      wr_acc_reg[9*wr_piece_reg +: 9] <= write_port.data[8:0];
      if (cfg_reg.in_w == MQF_W18) begin
        wr_acc_reg[17:0] <= write_port.data[17:0];
      end
      wr_piece_reg <= wr_piece_reg + 2'd1;
    end else if (wr_commit) begin
      wr_piece_reg <= '0;
    end
  end

  // Storage write, one word per cycle into the selected queue
  always_ff @(posedge aclk) begin
    if (wr_commit) begin // see R2, R14
      mem[AW'(base_reg[wsel] + wptr_reg[wsel])] <= commit_word;
    end
  end

  // Read side pops only the word on show, so a select change never loses data
  assign rd_last = rd_piece_reg == mqf_last_piece(cfg_reg.out_w);
  assign pop = read_port.rd_en && out_valid_reg && rd_last;
  assign prst = !partial_reset_n && wsel == rsel; // see R12
  assign active_vec = NQ'((5'h2 << cfg_reg.qnum_m1) - 5'h1);

  // Per-queue pointers, counts and flags
  for (genvar q = 0; q < NQ; q++) begin : g_queue
    logic wr_here, pop_here, clr_here;
    assign wr_here = wr_commit && wsel == QSEL_W'(q);
    assign pop_here = pop && shown_q_reg == QSEL_W'(q);
    assign clr_here = prst && wsel == QSEL_W'(q);
    assign cnt_next[q] = clr_here ? '0 : cnt_reg[q] + CW'(wr_here) - CW'(pop_here);
    assign rptr_next[q] = clr_here ? '0 : !pop_here ? rptr_reg[q] :
                          (rptr_reg[q] + CW'(1) == depth_reg[q]) ? '0 : rptr_reg[q] + CW'(1);
    assign full_vec[q] = cnt_reg[q] >= depth_reg[q]; // see R3
    assign empty_vec[q] = cnt_reg[q] == '0;
    assign pkt_rdy_vec[q] = cfg_reg.pkt_mode && eop_cnt_reg[q] != '0; // see R7
    assign af_vec[q] = active_vec[q] &&
                       ({1'b0, cnt_reg[q]} + 17'(af_off_reg[q]) >= 17'(depth_reg[q])); // see R4
    assign ae_vec[q] = active_vec[q] &&
                       (cfg_reg.pkt_mode ? !pkt_rdy_vec[q] : 17'(cnt_reg[q]) <= 17'(ae_off_reg[q]));

    always_ff @(posedge aclk) begin
      if (!aresetn || cfg_apply) begin
        wptr_reg[q] <= '0;
        rptr_reg[q] <= '0;
        cnt_reg[q] <= '0;
        eop_cnt_reg[q] <= '0;
      end else begin
        cnt_reg[q] <= cnt_next[q];
        rptr_reg[q] <= rptr_next[q];
        if (clr_here) begin
          wptr_reg[q] <= '0;
        end else if (wr_here) begin
          wptr_reg[q] <= (wptr_reg[q] + CW'(1) == depth_reg[q]) ? '0 : wptr_reg[q] + CW'(1);
        end
        // Complete packets counted by their end markers
        if (clr_here || !cfg_reg.pkt_mode) begin
          eop_cnt_reg[q] <= '0;
        end else begin // see R18
          eop_cnt_reg[q] <= eop_cnt_reg[q] + CW'(wr_here && commit_word[EOP_BIT]) -
                            CW'(pop_here && out_reg[EOP_BIT]);
        end
      end
    end

    // Occupancy never passes the queue's depth
    property p_no_overfill;
      @(posedge aclk) disable iff (!aresetn) cnt_reg[q] <= depth_reg[q];
    endproperty
    a_no_overfill: assert property (p_no_overfill) else $error("queue overfilled"); // see R16

    // Queue bases land on block boundaries
    property p_block_base;
      @(posedge aclk) disable iff (!aresetn) base_reg[q][7:0] == 8'h00;
    endproperty
    a_block_base: assert property (p_block_base) else $error("base off block"); // see R11
  end

  // Next head: the word being written when the queue is otherwise empty
  assign head_word = (cnt_reg[rsel] - CW'(pop && shown_q_reg == rsel) == '0) ? commit_word :
                     mem[AW'(base_reg[rsel] + rptr_next[rsel])];
  assign need_load = !out_valid_reg || pop || shown_q_reg != rsel || prst;

  // Fall-through output register; narrow reads shift the word down
  always_ff @(posedge aclk) begin
    if (!aresetn || cfg_apply) begin
      out_reg <= '0;
      out_valid_reg <= 1'b0;
      shown_q_reg <= '0;
      rd_piece_reg <= '0;
    end else if (need_load) begin
      shown_q_reg <= rsel;
      rd_piece_reg <= '0;
      out_valid_reg <= cnt_next[rsel] != '0; // see R13, R19
      if (cnt_next[rsel] != '0) begin
        out_reg <= head_word;
      end // Empty queue: last word stays put, see R17
    end else if (read_port.rd_en) begin // see R6
      out_reg <= out_reg >> mqf_piece_bits(cfg_reg.out_w);
      rd_piece_reg <= rd_piece_reg + 2'd1;
    end
  end

  // Flag buses, registered, driven only when this device is addressed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      af_bus_reg <= '0;
      ae_bus_reg <= '0;
    end else begin
      af_bus_reg <= af_vec;
      ae_bus_reg <= ae_vec;
    end
  end
  assign almost_full_flag = af_bus_reg;
  assign almost_empty_flag = ae_bus_reg;
  assign almost_full_flag_oe = af_bus_select == DEVICE_INDEX; // see R15
  assign almost_empty_flag_oe = ae_bus_select == DEVICE_INDEX;
  assign read_data = out_reg;
  assign read_word_valid = out_valid_reg;
  assign write_queue_full = full_vec[wsel];
  assign packet_available_flag = pkt_rdy_vec[shown_q_reg] && out_valid_reg;

  // Sticky events; a new event beats a same-cycle clear
  assign irq_event[IRQ_OVF] = write_port.wr_en && full_vec[wsel];
  assign irq_event[IRQ_UNF] = read_port.rd_en && !out_valid_reg;
  assign irq_event[IRQ_CFG] = cfg_apply && !cfg_ok;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_reg <= '0;
    end else if (do_write && awaddr_reg == REG_IRQ_STAT && wstrb_reg[0]) begin
      irq_stat_reg <= (irq_stat_reg & ~wdata_reg[IRQ_W-1:0]) | irq_event;
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_event;
    end
  end
  assign irq = |(irq_stat_reg & irq_mask_reg);

  // Checks on the running setup and the ports
  property p_one_wide;
    @(posedge aclk) disable iff (!aresetn) cfg_reg.in_w == MQF_W36 || cfg_reg.out_w == MQF_W36;
  endproperty
  a_one_wide: assert property (p_one_wide) else $error("no wide port"); // see R5

  property p_pkt_wide;
    @(posedge aclk) disable iff (!aresetn)
      cfg_reg.pkt_mode |-> cfg_reg.in_w == MQF_W36 && cfg_reg.out_w == MQF_W36;
  endproperty
  a_pkt_wide: assert property (p_pkt_wide) else $error("packet mode on narrow port"); // see R7

  property p_valid_backed;
    @(posedge aclk) disable iff (!aresetn) out_valid_reg |-> cnt_reg[shown_q_reg] != '0;
  endproperty
  a_valid_backed: assert property (p_valid_backed) else $error("valid with no word"); // see R19

  property p_partial_clear;
    @(posedge aclk) disable iff (!aresetn) prst && !cfg_apply |=> cnt_reg[$past(rsel)] == '0;
  endproperty
  a_partial_clear: assert property (p_partial_clear) else $error("partial reset kept data"); // see R12

  property p_write_counts;
    @(posedge aclk) disable iff (!aresetn)
      wr_commit && !(pop && shown_q_reg == wsel) && !prst && !cfg_apply
      |=> cnt_reg[$past(wsel)] == $past(cnt_reg[wsel]) + CW'(1);
  endproperty
  a_write_counts: assert property (p_write_counts) else $error("write not counted"); // see R14

  sequence s_write_into_empty;
    wr_commit && wsel == rsel && cnt_reg[rsel] == '0 && !prst && !cfg_apply;
  endsequence
  sequence s_word_shown;
    ##1 out_valid_reg && out_reg == $past(commit_word);
  endsequence
  property p_fall_through;
    @(posedge aclk) disable iff (!aresetn) s_write_into_empty |-> s_word_shown;
  endproperty
  a_fall_through: assert property (p_fall_through) else $error("word did not fall through"); // see R13

  property p_keep_last;
    @(posedge aclk) disable iff (!aresetn)
      !out_valid_reg && cnt_next[rsel] == '0 && !cfg_apply |=> $stable(read_data);
  endproperty
  a_keep_last: assert property (p_keep_last) else $error("output word lost"); // see R17

  property p_idle_queue_flags;
    @(posedge aclk) disable iff (!aresetn)
      !active_vec[3] ##1 1'b1 |-> !almost_full_flag[3] && !almost_empty_flag[3];
  endproperty
  a_idle_queue_flags: assert property (p_idle_queue_flags) else $error("flag on idle queue"); // see R4
endmodule : mqf_top
`default_nettype wire

// File: design/mqf_pkg.sv
// Package: constants, types and helpers of the multi-queue flow FIFO
package mqf_pkg;
  localparam int NQ = 4;
  localparam int DW = 36;
  localparam int QSEL_W = 2;
  localparam int BLOCK_WORDS = 256;
  localparam int TOTAL_BLOCKS_DEF = 64;
  localparam int SOP_BIT = 34;
  localparam int EOP_BIT = 35;
  localparam int THR_W = 16;
  localparam int EXP_W = 3;
  localparam int AXI_AW = 8;
  localparam int QBLK_W = 8;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [7:0] REG_QBLK = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_IRQ_STAT = 8'h10;
  localparam logic [7:0] REG_IRQ_MASK = 8'h14;
  localparam logic [7:0] REG_AF_BASE = 8'h20;
  localparam logic [7:0] REG_AE_BASE = 8'h30;
  localparam logic [7:0] REG_QCNT_BASE = 8'h40;
  // Values after reset
  localparam logic [15:0] AF_OFF_RESET = 16'h0008;
  localparam logic [15:0] AE_OFF_RESET = 16'h0008;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
  // Interrupt status bit positions
  localparam int IRQ_W = 3;
  localparam int IRQ_OVF = 0;
  localparam int IRQ_UNF = 1;
  localparam int IRQ_CFG = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {MQF_W36, MQF_W18, MQF_W9} mqf_width_t;

  typedef struct packed {
    logic pkt_mode;
    mqf_width_t out_w;
    mqf_width_t in_w;
    logic [1:0] qnum_m1;
  } mqf_cfg_t;

  localparam mqf_cfg_t CFG_RESET = '{pkt_mode: 1'b0, out_w: MQF_W36, in_w: MQF_W36,
                                     qnum_m1: 2'h3};

  typedef struct packed {
    logic wr_en;
    logic [QSEL_W-1:0] write_queue_select;
    logic [DW-1:0] data;
  } mqf_wr_port_t;

  typedef struct packed {
    logic rd_en;
    logic [QSEL_W-1:0] read_queue_select;
  } mqf_rd_port_t;

  // Bits carried by one transfer at a port of the given width
  function automatic logic [5:0] mqf_piece_bits(mqf_width_t w);
    unique case (w)
      MQF_W18: mqf_piece_bits = 6'd18;
      MQF_W9: mqf_piece_bits = 6'd9;
      default: mqf_piece_bits = 6'd36;
    endcase
  endfunction : mqf_piece_bits

  // Index of the last transfer that makes up one 36-bit word
  function automatic logic [1:0] mqf_last_piece(mqf_width_t w);
    unique case (w)
      MQF_W18: mqf_last_piece = 2'd1;
      MQF_W9: mqf_last_piece = 2'd3;
      default: mqf_last_piece = 2'd0;
    endcase
  endfunction : mqf_last_piece
endpackage : mqf_pkg

// File: bench/mqf_host.sv
// Host-side write controller model that faces the write port
`timescale 1ns/100ps
`default_nettype none
module mqf_host
  import mqf_pkg::*;
(
  input wire logic wr_req,
  input wire logic force_wr,
  input wire logic [1:0] wr_sel,
  input wire logic [35:0] wr_word,
  input wire logic write_queue_full,
  output var mqf_pkg::mqf_wr_port_t write_port
);
  // Strobe held back while full; force_wr exists only to provoke a refusal
  assign write_port = '{wr_en: wr_req && (force_wr || !write_queue_full),
                        write_queue_select: wr_sel, data: wr_word};
endmodule : mqf_host
`default_nettype wire

// File: bench/multi_queue_flow_fifo_tb_top.sv
// Self-checking bench for the multi-queue flow FIFO
`timescale 1ns/100ps
`default_nettype none
`define CK(a, e) begin cmp_count++; if ((a) !== (e)) begin bad_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module multi_queue_flow_fifo_tb_top;
  import mqf_pkg::*;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bv, arv = 0, rv, prn = 1;
  logic wreq = 0, fwr = 0, aw_r, w_r, ar_r, rwv, wqf, irq, afoe, aeoe, pkt;
  logic [7:0] awa = 0, ara = 0;
  logic [2:0] fsel = 0;
  logic [31:0] wd = 0, rd_d, rdat;
  logic [1:0] br, rr, rresp, wresp, wsel = 0;
  logic [35:0] wword = 0, rdata, shown;
  logic [3:0] aff, aef;
  mqf_wr_port_t wp;
  mqf_rd_port_t rp = '0;
  int bad_count = 0, cmp_count = 0, n;
  mqf_host u_mqf_host(.wr_req(wreq), .force_wr(fwr), .wr_sel(wsel), .wr_word(wword),
    .write_queue_full(wqf), .write_port(wp));
  // Four blocks give 256-word queues so a fill stays short
  mqf_top #(.TOTAL_BLOCKS(4)) u_mqf_top(.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(aw_r), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv), .s_axi_wready(w_r), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(ar_r),
    .s_axi_rdata(rd_d), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(1'b1),
    .write_port(wp), .read_port(rp), .partial_reset_n(prn), .af_bus_select(fsel),
    .ae_bus_select(fsel), .read_data(rdata), .read_word_valid(rwv), .write_queue_full(wqf),
    .packet_available_flag(pkt), .almost_full_flag(aff), .almost_full_flag_oe(afoe),
    .almost_empty_flag(aef), .almost_empty_flag_oe(aeoe), .irq(irq));
  initial begin
    forever #10 aclk = ~aclk;
  end
  task automatic tick(input int k);
    repeat (k) @(posedge aclk);
  endtask : tick
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run
  task automatic expire(input int k);
    if (k >= 200) begin
      bad_count++;
      complete_run();
    end
  endtask : expire
  // Write offers address and data together; ready is high while idle, so waits end on bvalid
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    awa <= a; wd <= d; awv <= 1; wv <= 1;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (aw_r) awv <= 0;
      if (w_r) wv <= 0;
      if (bv) break;
    end
    wresp = br;
    expire(n);
  endtask : axw
  task automatic axr(input logic [7:0] a);
    ara <= a; arv <= 1;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (ar_r) arv <= 0;
      if (rv) break;
    end
    rdat = rd_d; rresp = rr;
    expire(n);
  endtask : axr
  initial begin
    tick(20);
    aresetn <= 1;
    tick(3);
    `CK(aef, 4'hf)
    `CK(aff, 4'h0)
    axr(REG_CFG); `CK(rdat, 32'h0000_0003)
    axr(8'hFC); `CK(rresp, RESP_SLVERR)
    // One word into queue 1 while the read side looks at queue 1
    rp.read_queue_select <= 2'h1; wsel <= 2'h1; wword <= 36'h9_1234_5678; wreq <= 1;
    tick(1); wreq <= 0; tick(2);
    `CK(rwv, 1'b1)
    `CK(rdata, 36'h9_1234_5678)
    shown = rdata;
    // Empty queue must leave the old word on show
    rp.read_queue_select <= 2'h2; tick(2);
    `CK(rwv, 1'b0)
    `CK(rdata, shown)
    rp.read_queue_select <= 2'h1; tick(2);
    rp.rd_en <= 1; tick(1); rp.rd_en <= 0; tick(1);
    `CK(rwv, 1'b0)
    // Back-to-back writes into queue 0 until it refuses
    wsel <= 2'h0; wreq <= 1;
    for (int i = 0; i < 300 && !wqf; i++) begin
      wword <= 36'(i); tick(1);
    end
    wreq <= 0; tick(2);
    `CK(wqf, 1'b1)
    `CK(aff[0], 1'b1)
    axr(REG_QCNT_BASE); `CK(rdat, 32'h0000_0100)
    // Write while full is refused and raises the overflow event
    fwr <= 1; wreq <= 1; tick(1); fwr <= 0; wreq <= 0;
    axw(REG_IRQ_MASK, 32'h0000_0001); tick(1); `CK(irq, 1'b1)
    axw(REG_IRQ_STAT, 32'h0000_0001); tick(1); `CK(irq, 1'b0)
    axr(REG_QCNT_BASE); `CK(rdat, 32'h0000_0100)
    // Partial reset with both selects on queue 0 empties it
    rp.read_queue_select <= 2'h0; tick(2); prn <= 0; tick(1); prn <= 1; tick(2);
    `CK(wqf, 1'b0)
    axr(REG_QCNT_BASE); `CK(rdat, 32'h0000_0000)
    // Flag buses answer only their own expansion address
    `CK({afoe, aeoe}, 2'b11)
    fsel <= 3'h5; tick(1); `CK({afoe, aeoe}, 2'b00)
    axw(8'hFC, 32'h0000_0000); `CK(wresp, RESP_SLVERR)
    // x18 in: first piece lands in the low half of the word
    axw(REG_CFG, 32'h0000_0007); axw(REG_CTRL, 32'h0000_0001);
    rp.read_queue_select <= 2'h2; wsel <= 2'h2; wword <= 36'h0_0001_2345; wreq <= 1;
    tick(1); wword <= 36'h0_0002_abcd; tick(1); wreq <= 0; tick(1);
    `CK(rdata, {18'h2_abcd, 18'h1_2345})
    // x9 out: low nine bits first, then the next nine
    axw(REG_CFG, 32'h0000_0023); axw(REG_CTRL, 32'h0000_0001);
    wword <= 36'h8_7654_3210; wreq <= 1; tick(1); wreq <= 0; tick(1);
    `CK(rdata[8:0], wword[8:0])
    rp.rd_en <= 1; tick(1); rp.rd_en <= 0; tick(1);
    `CK(rdata[8:0], wword[17:9])
    // Packet mode on three queues: a marked packet is reported, queue 3 lies idle
    axw(REG_CFG, 32'h0000_0042); axw(REG_CTRL, 32'h0000_0001);
    wword <= 36'h4_0000_0001; wreq <= 1; tick(1); wword <= 36'h8_0000_0002;
    tick(1); wreq <= 0; tick(2);
    `CK(pkt, 1'b1)
    `CK(aef[2], 1'b0)
    `CK({aef[3], aff[3]}, 2'b00)
    wsel <= 2'h3; tick(1); `CK(wqf, 1'b1)
    // Neither port wide: the setup is refused and reported
    axw(REG_CFG, 32'h0000_001b); axw(REG_CTRL, 32'h0000_0001);
    axr(REG_IRQ_STAT); `CK(rdat, 32'h0000_0004)
    complete_run();
  end
endmodule : multi_queue_flow_fifo_tb_top
`default_nettype wire
